// ---- common/cx_pkg.sv ----
/*
 coexistence block constants: register offsets, field positions, reset
 values and pin function codes.
 assumes a plain register port with 32-bit data, word offsets in bytes.
*/
package cx_pkg;
	// ==========================================================
	// register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] PRIO_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] PINSEL_OFS = 8'h0c;
	// ==========================================================
	// control register fields
	localparam int CTRL_GATE_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// ==========================================================
	// priority register fields
	localparam int PRIO_OWNER_BIT = 0;
	localparam logic [31:0] PRIO_RST = 32'h0000_0000;
	// ==========================================================
	// status register fields
	localparam int STAT_ACT_BIT = 0;
	localparam int STAT_PRI_BIT = 1;
	localparam int STAT_EXT_BIT = 2;
	localparam int STAT_INH_BIT = 3;
	localparam int STAT_ENV_BIT = 4;
	localparam int STAT_ARMED_BIT = 5;
	// ==========================================================
	// pin function select fields and codes
	localparam int PIN_FUNC_W = 6;
	localparam int PIN_IDX_W = 6;
	localparam logic [31:0] PINSEL_RST = 32'h0000_0000;
	localparam logic [5:0] FN_EXT_A = 6'h30;
	localparam logic [5:0] FN_EXT_B = 6'h31;
	localparam logic [5:0] FN_ACTIVE = 6'h32;
	localparam logic [5:0] FN_PRIORITY = 6'h33;
	localparam int NUM_PINS = 32;
	// owner encodings
	localparam logic OWNER_EXT = 1'b0;
	localparam logic OWNER_MAC = 1'b1;
endpackage

// ---- hdl/cx_sync.sv ----
/*
 two-flop synchroniser for one level.
 assumes the input is a plain level, possibly from another clock.
*/
`timescale 1ns/100ps
module cx_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic d,
	output logic q
);
	logic meta_r;
	// ==========================================================
	// first flop feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// ---- hdl/cx_pinmux.sv ----
/*
 pin function mux: routes the two activity inputs from chosen pins and
 the two outputs onto pins whose function code selects them.
 assumes a function code per pin, held by the caller.
*/
`timescale 1ns/100ps
module cx_pinmux #(
	parameter int PINS = cx_pkg::NUM_PINS
) (
	input wire logic [PINS*cx_pkg::PIN_FUNC_W-1:0] func,
	input wire logic [PINS-1:0] pin_in,
	input wire logic act_out,
	input wire logic pri_out,
	output logic ext_a,
	output logic ext_b,
	output logic [PINS-1:0] pin_out,
	output logic [PINS-1:0] pin_oe
);
	logic [PINS-1:0] hit_a;
	logic [PINS-1:0] hit_b;
	// ==========================================================
	// per-pin decode
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_pin
			wire [5:0] fn = func[g*cx_pkg::PIN_FUNC_W +: cx_pkg::PIN_FUNC_W];
			wire is_act = (fn == cx_pkg::FN_ACTIVE);
			wire is_pri = (fn == cx_pkg::FN_PRIORITY);
			assign hit_a[g] = (fn == cx_pkg::FN_EXT_A) & pin_in[g];
			assign hit_b[g] = (fn == cx_pkg::FN_EXT_B) & pin_in[g];
			assign pin_out[g] = (is_act & act_out) | (is_pri & pri_out);
			assign pin_oe[g] = is_act | is_pri;
		end
	endgenerate
	// several pins on one function simply OR together
	assign ext_a = |hit_a;
	assign ext_b = |hit_b;
endmodule

// ---- hdl/cx_top.sv ----
/*
 coexistence signalling: tells external radios when the local radio is
 active and whether it holds priority, and inhibits local activity when
 an external radio with precedence is busy.
 assumes the radio domain is powered and its clock running before any
 register access; pins are synchronous to SYS_CLK apart from the
 external activity inputs, which are synchronised here.
*/
// The register offsets and the address-and-strobe port were left to the implementer.
// Notes on behaviour
// - active output high while local radio transmits or receives
// - priority output shows whether local radio currently holds priority
// - any pin takes activity input a or b by function codes 48/49
// - codes 50 and 51 route active and priority outputs to a pin
// - gating off: active output asserted for local activity unless lacking priority with external activity
// - gating on: active output only when local side owns priority
// - lacking priority, both outputs low while external activity high
// - lacking priority with external activity, inhibit local radio
// - gating off: rise with envelope, fall after envelope and done
// - gating off, local owner: priority output mirrors active output
// - external owner: priority output low whenever external active
// - gating on, local owner: active and priority rise together
// - envelope input covers whole event, receive and transmit
`timescale 1ns/100ps
module cx_top #(
	parameter int PINS = cx_pkg::NUM_PINS
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic MAC_EVENT_ENV,
	input wire logic MAC_ACT_DONE,
	output logic RADIO_INHIBIT,
	input wire logic [PINS-1:0] PIN_IN,
	output logic [PINS-1:0] PIN_OUT,
	output logic [PINS-1:0] PIN_OE
);
	localparam int FW = PINS * cx_pkg::PIN_FUNC_W;
	// ==========================================================
	// registers
	logic gate_r;
	logic owner_r;
	logic [FW-1:0] func_r;
	logic [cx_pkg::PIN_IDX_W-1:0] sel_idx;
	logic [cx_pkg::PIN_FUNC_W-1:0] sel_code;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic act_r;
	logic act_nxt;
	logic armed_r;
	logic env_d_r;
	logic ext_a_raw;
	logic ext_b_raw;
	logic ext_a_s;
	logic ext_b_s;
	logic ext_any;
	logic local_pri;
	logic lose;
	logic env_rise;
	logic hold;
	logic act_out;
	logic pri_out;
	logic [31:0] status;

	// ==========================================================
	// register writes; pin select register writes one pin's code
	// through an index field so the whole map fits one word
	assign sel_idx = REG_WDATA[8 +: cx_pkg::PIN_IDX_W];
	assign sel_code = REG_WDATA[0 +: cx_pkg::PIN_FUNC_W];

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gate_r <= cx_pkg::CTRL_RST[cx_pkg::CTRL_GATE_BIT];
			owner_r <= cx_pkg::PRIO_RST[cx_pkg::PRIO_OWNER_BIT];
			func_r <= '0;
		end else if (REG_WR) begin
			if (REG_ADDR == cx_pkg::CTRL_OFS) begin
				gate_r <= REG_WDATA[cx_pkg::CTRL_GATE_BIT];
			end
			if (REG_ADDR == cx_pkg::PRIO_OFS) begin
				owner_r <= REG_WDATA[cx_pkg::PRIO_OWNER_BIT];
			end
			if (REG_ADDR == cx_pkg::PINSEL_OFS && 32'(sel_idx) < PINS) begin
				func_r[sel_idx*cx_pkg::PIN_FUNC_W +: cx_pkg::PIN_FUNC_W]
					<= sel_code;
			end
		end
	end

	// ==========================================================
	// pin routing and input synchronisers
	cx_pinmux #(.PINS(PINS)) u_mux (
		.func(func_r),
		.pin_in(PIN_IN),
		.act_out(act_out),
		.pri_out(pri_out),
		.ext_a(ext_a_raw),
		.ext_b(ext_b_raw),
		.pin_out(PIN_OUT),
		.pin_oe(PIN_OE)
	);

	// the far radios raise these before they transmit
	cx_sync u_sync_a (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.d(ext_a_raw),
		.q(ext_a_s)
	);
	cx_sync u_sync_b (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.d(ext_b_raw),
		.q(ext_b_s)
	);
	// both radios share one priority setting
	assign ext_any = ext_a_s | ext_b_s;

	// ==========================================================
	// priority decision
	assign local_pri = (owner_r == cx_pkg::OWNER_MAC);
	// only an external owner with a busy radio makes us lose
	assign lose = !local_pri && ext_any;
	assign RADIO_INHIBIT = lose;

	// ==========================================================
	// activity envelope: envelope spans rx and tx of one event
	assign env_rise = MAC_EVENT_ENV && !env_d_r;
	// after the envelope falls keep asserting until the last activity
	// reports done; done while envelope high is ignored
	assign hold = act_r && !MAC_ACT_DONE;

	always_comb begin
		act_nxt = act_r;
		if (!armed_r && !env_rise) begin
			act_nxt = 1'b0;
		end else if (MAC_EVENT_ENV) begin
			act_nxt = 1'b1;
		end else begin
			act_nxt = hold;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			act_r <= 1'b0;
			armed_r <= 1'b0;
			env_d_r <= 1'b0;
		end else begin
			act_r <= act_nxt;
			env_d_r <= MAC_EVENT_ENV;
			if (env_rise) begin
				armed_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// outputs: the rise follows the envelope combinationally so the
	// active line tracks the envelope edge with no lag
	wire local_act = armed_r | env_rise ? (MAC_EVENT_ENV | act_r) : 1'b0;
	// gate off: show activity unless we lose; gate on: only with priority
	assign act_out = gate_r ? (local_act && local_pri)
		: (local_act && !lose);
	// local owner: priority follows activity; external owner: low
	// while the far side is busy, otherwise local activity (the active waveform only with gate off)
	assign pri_out = local_pri ? act_out
		: (local_act && !ext_any);

	// ==========================================================
	// status and read path
	always_comb begin
		status = '0;
		status[cx_pkg::STAT_ACT_BIT] = act_out;
		status[cx_pkg::STAT_PRI_BIT] = pri_out;
		status[cx_pkg::STAT_EXT_BIT] = ext_any;
		status[cx_pkg::STAT_INH_BIT] = lose;
		status[cx_pkg::STAT_ENV_BIT] = MAC_EVENT_ENV;
		status[cx_pkg::STAT_ARMED_BIT] = armed_r;
	end

	always_comb begin
		rdata_nxt = '0;
		if (REG_RD) begin
			unique case (REG_ADDR)
				cx_pkg::CTRL_OFS: rdata_nxt = {31'h0, gate_r};
				cx_pkg::PRIO_OFS: rdata_nxt = {31'h0, owner_r};
				cx_pkg::STAT_OFS: rdata_nxt = status;
				default: rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign REG_RDATA = rdata_r;
endmodule

// ---- tb/cx_top_sva.sv ----
/* checker for the coexistence top ports.
 assumes ext inputs on pins PA/PB and outputs on PACT/PPRI. */
`timescale 1ns/100ps
module cx_chk #(
	parameter int PINS = 32,
	parameter int PA = 3,
	parameter int PB = 4,
	parameter int PACT = 5,
	parameter int PPRI = 6
) (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic MAC_EVENT_ENV,
	input wire logic MAC_ACT_DONE,
	input wire logic RADIO_INHIBIT,
	input wire logic [PINS-1:0] PIN_IN,
	input wire logic [PINS-1:0] PIN_OUT,
	input wire logic [PINS-1:0] PIN_OE
);
	// ==========================================================
	// shadow of the settings, tracked from the register port
	logic gate_r, mac_r, seen_r;
	wire act = PIN_OUT[PACT];
	wire pri = PIN_OUT[PPRI];
	wire ext = PIN_IN[PA] | PIN_IN[PB];
	wire map = PIN_OE[PACT] & PIN_OE[PPRI];
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			gate_r <= 1'b0;
			mac_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			seen_r <= seen_r | MAC_EVENT_ENV;
			if (REG_WR && REG_ADDR == cx_pkg::CTRL_OFS)
				gate_r <= REG_WDATA[cx_pkg::CTRL_GATE_BIT];
			if (REG_WR && REG_ADDR == cx_pkg::PRIO_OFS)
				mac_r <= REG_WDATA[cx_pkg::PRIO_OWNER_BIT];
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);
	AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside read slot");
	AST_ENV_ACT: assert property (
		map && MAC_EVENT_ENV && !gate_r && mac_r |-> act)
		else $error("active not raised with envelope");
	AST_MIRROR: assert property (map && !gate_r && mac_r |-> pri == act)
		else $error("priority differs from active");
	AST_TOGETHER: assert property (
		map && gate_r && mac_r && $rose(act) |-> pri)
		else $error("active rose without priority");
	AST_GATED: assert property (map && gate_r && !mac_r |-> !act)
		else $error("active raised without priority");
	AST_EXT_QUIET: assert property (
		map && !mac_r && ext && $past(ext) && $past(ext, 2) |-> !act && !pri)
		else $error("outputs high during external activity");
	AST_INHIBIT: assert property (
		!mac_r && ext && $past(ext) && $past(ext, 2) |-> RADIO_INHIBIT)
		else $error("local radio not inhibited");
	AST_HOLD: assert property (
		map && mac_r && act && !MAC_EVENT_ENV && !MAC_ACT_DONE |=> act)
		else $error("active dropped before completion");
	AST_DROP: assert property (
		map && act && !MAC_EVENT_ENV && MAC_ACT_DONE |=> MAC_EVENT_ENV || !act)
		else $error("active held after completion");
	// the first envelope cycle itself may already show activity
	AST_QUIET: assert property (
		map && !seen_r && !MAC_EVENT_ENV |-> !act && !pri)
		else $error("output high before first envelope");
endmodule
bind cx_top cx_chk #(.PINS(PINS)) i_chk (.*);

// ---- tb/cx_ext_radio.sv ----
/* behavioural external radio: raises its activity line for len cycles.
 assumes go is a one-cycle pulse; the line is driven low when idle. */
`timescale 1ns/100ps
module cx_ext_radio (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [7:0] len,
	output logic act
);
	logic [7:0] cnt_r;
	assign act = (cnt_r != 8'h00);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_r <= 8'h00;
		else if (go)
			cnt_r <= len;
		else if (cnt_r != 8'h00)
			cnt_r <= cnt_r - 8'h01;
	end
endmodule

// ---- tb/tb_radio_coexistence_signalling.sv ----
/* self-checking bench for the coexistence top.
 assumes ext radios on pins 3/4, outputs mapped to pins 5/6. */
`timescale 1ns/100ps
module tb_radio_coexistence_signalling;
	logic clk, rst_n, wr, rd, env, done, inh, go_a, go_b;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, pout, poe, v;
	wire ext_a, ext_b;
	wire [31:0] pin = {27'h0, ext_b, ext_a, 3'h0};
	int fails = 0;
	int checked = 0;
	cx_top i_dut (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.MAC_EVENT_ENV(env), .MAC_ACT_DONE(done), .RADIO_INHIBIT(inh),
		.PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe));
	cx_ext_radio i_ra (.clk(clk), .rst_n(rst_n), .go(go_a), .len(8'h14),
		.act(ext_a));
	cx_ext_radio i_rb (.clk(clk), .rst_n(rst_n), .go(go_b), .len(8'h14),
		.act(ext_b));
	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata;
	endtask
	// e is {inhibit, priority, active}
	task automatic outs(input logic [2:0] e);
		@(negedge clk);
		chk({29'h0, inh, pout[6:5]}, {29'h0, e});
	endtask
	task automatic pinsel(input logic [5:0] idx, input logic [5:0] fn);
		wr_reg(cx_pkg::PINSEL_OFS, {18'h0, idx, 2'h0, fn});
	endtask
	task automatic end_evt();
		@(posedge clk);
		env <= 1'b0;
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
	endtask
	task automatic summarize();
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_setup();
		outs(3'b000);
		rd_reg(cx_pkg::CTRL_OFS);
		chk(v, cx_pkg::CTRL_RST);
		rd_reg(cx_pkg::PRIO_OFS);
		chk(v, cx_pkg::PRIO_RST);
		rd_reg(8'h10);
		chk(v, 32'h0);
		pinsel(6'h03, cx_pkg::FN_EXT_A);
		pinsel(6'h04, cx_pkg::FN_EXT_B);
		pinsel(6'h05, cx_pkg::FN_ACTIVE);
		pinsel(6'h06, cx_pkg::FN_PRIORITY);
		pinsel(6'h28, cx_pkg::FN_ACTIVE);
		@(negedge clk);
		chk(poe, 32'h0000_0060);
		rd_reg(cx_pkg::PINSEL_OFS);
		chk(v, 32'h0);
		outs(3'b000);
		$display("setup test finished");
	endtask
	task automatic t_gate_off();
		wr_reg(cx_pkg::PRIO_OFS, 32'h1);
		@(posedge clk);
		env <= 1'b1;
		outs(3'b011);
		rd_reg(cx_pkg::STAT_OFS);
		chk(v, 32'h0000_0033);
		@(posedge clk);
		env <= 1'b0;
		repeat (3) @(posedge clk);
		outs(3'b011);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		outs(3'b000);
		$display("gate off test finished");
	endtask
	task automatic t_ext();
		int n;
		wr_reg(cx_pkg::PRIO_OFS, 32'h0);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			go_a <= (i == 0);
			go_b <= (i == 1);
			env <= 1'b1;
			@(posedge clk);
			go_a <= 1'b0;
			go_b <= 1'b0;
			repeat (3) @(posedge clk);
			outs(3'b100);
			rd_reg(cx_pkg::STAT_OFS);
			chk(v, 32'h0000_003c);
			n = 0;
			while ((ext_a | ext_b) && n < 50) begin
				@(posedge clk);
				n++;
			end
			if (n == 50) begin
				fails++;
				summarize();
			end
			repeat (3) @(posedge clk);
			outs(3'b011);
			end_evt();
		end
		$display("external owner test finished");
	endtask
	task automatic t_gate_on();
		wr_reg(cx_pkg::CTRL_OFS, 32'h1);
		wr_reg(cx_pkg::PRIO_OFS, 32'h1);
		@(posedge clk);
		env <= 1'b1;
		outs(3'b011);
		end_evt();
		wr_reg(cx_pkg::PRIO_OFS, 32'h0);
		@(posedge clk);
		env <= 1'b1;
		@(negedge clk);
		chk({31'h0, pout[5]}, 32'h0);
		end_evt();
		$display("gate on test finished");
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		env = 1'b0;
		done = 1'b0;
		go_a = 1'b0;
		go_b = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		repeat (16) @(posedge clk);
		// radio domain powered and clocked from reset on; registers
		// are only touched after this release
		rst_n <= 1'b1;
		t_setup();
		t_gate_off();
		t_ext();
		t_gate_on();
		summarize();
	end
endmodule
